// >>> external_data_space_access_address_gen.sv
// Purpose: effective address forming and on-chip routing of external-move accesses
// Assumes: core holds its request fields stable while req_i is high until done_o
// Notes: the off-chip port and flash writer are outside; this block hands them the address
//        ce_i low freezes the on-chip store as well as the control state
`timescale 1ns/1ps
module external_data_space_access_address_gen import external_data_space_access_pkg::*; #(
	parameter int RAM_BYTES = EXTERNAL_DATA_SPACE_BYTES,
	parameter bit HAS_OFFCHIP_PORT = 1'b1
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// core request
	input wire logic req_i,
	input wire move_req_s move_i,
	input wire logic [7:0] indirect_pointer_reg0_i,
	input wire logic [7:0] indirect_pointer_reg1_i,
	// special function register writes from the core
	input wire logic [1:0] sfr_sel_i,
	input wire logic sfr_we_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic data_pointer_load_i,
	input wire logic [15:0] data_pointer_wdata_i,
	// target selection
	input wire logic flash_write_en_i,
	input wire logic offchip_sel_i,
	// far side answer
	input wire logic far_done_i,
	input wire logic [7:0] far_rdata_i,
	// results
	output logic done_o,
	output logic [7:0] acc_rdata_o,
	output logic [15:0] eff_addr_o,
	output logic [7:0] data_pointer_high_half_o,
	output logic [7:0] data_pointer_low_half_o,
	output logic [7:0] external_data_space_page_select_reg_o,
	output far_req_s far_req_o
);
	// the store and its address slice follow the size parameter
	localparam int RAM_AW = $clog2(RAM_BYTES);

	// elaboration checks: only the 1k store is served, and the two-bit
	// latency counter must end on the package's last step
	if (RAM_BYTES != EXTERNAL_DATA_SPACE_BYTES) begin : g_bad_ram_size
		$error("ram size must be 1k bytes");
	end
	if (RAM_BYTES != (1 << RAM_AW)) begin : g_bad_ram_pow2
		$error("ram size must be a power of two");
	end
	if (EXTERNAL_DATA_SPACE_LATENCY != int'(LAT_LAST) + 1) begin : g_bad_latency
		$error("latency count does not match its last step");
	end

	// all state in one struct
	typedef struct packed {
		access_state_e state;
		logic [1:0] lat;
		logic [15:0] data_pointer;
		logic [7:0] page;
		logic [15:0] addr;
		logic done;
		logic [7:0] rdata;
		far_req_s far;
	} state_s;

	state_s state_reg;
	state_s state_next;
	logic [7:0] ram_rdata;
	logic ram_en;
	logic ram_we;

	// address forming used by request decode only; eff_addr_o shows the latched result
	// the 8-bit form never looks at the data pointer, the 16-bit form never at the page
	function automatic logic [15:0] form_addr(input move_req_s m, input logic [15:0] dp,
		input logic [7:0] pg, input logic [7:0] p0, input logic [7:0] p1);
		if (m.wide_form) begin
			form_addr = dp;
		end else begin
			form_addr = {pg, m.use_ptr1 ? p1 : p0};
		end
	endfunction : form_addr

	// ram strobe only on the first ram cycle; address held in state
	// one strobe per access keeps a held write from landing twice
	always_comb begin
		ram_en = (state_reg.state == ST_RAM) && (state_reg.lat == 2'h0);
		ram_we = ram_en && state_reg.far.is_write;
	end

	logic route_flash;
	logic route_off;
	// target choice for a new request; flash writes outrank the off-chip port
	always_comb begin
		route_flash = move_i.is_write && flash_write_en_i;
		route_off = HAS_OFFCHIP_PORT && offchip_sel_i;
	end

	// the store sees only the low address bits, so the 1k ram repeats through the space
	external_data_space_store #(
		.DEPTH(RAM_BYTES),
		.AW(RAM_AW)
	) u_store (
		.mclk_i(mclk_i),
		.ce_i(ce_i),
		.en_i(ram_en),
		.we_i(ram_we),
		.addr_i(state_reg.addr[RAM_AW-1:0]),
		.wdata_i(state_reg.far.wdata),
		.rdata_o(ram_rdata)
	);

	// next-state logic
	// pointer writes are taken in any state so the core never stalls on them;
	// a byte write in the same cycle as a full load overrides its half.
	// limitation: a request taken on the edge of a page or pointer write
	// forms its address from the old value, as an in-order core expects.
	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;
		// pointer and page registers, byte-wise or full load
		if (data_pointer_load_i) begin
			state_next.data_pointer = data_pointer_wdata_i;
		end
		if (sfr_we_i) begin
			case (sfr_sel_i)
				SFR_DP_HIGH: state_next.data_pointer[15:8] = sfr_wdata_i;
				SFR_DP_LOW: state_next.data_pointer[7:0] = sfr_wdata_i;
				SFR_PAGE: state_next.page = sfr_wdata_i;
				default: ;
			endcase
		end
		case (state_reg.state)
			ST_IDLE: begin
				if (req_i) begin
					// address and data are latched here so the core may change them after done
					state_next.addr = form_addr(move_i, state_reg.data_pointer, state_reg.page,
						indirect_pointer_reg0_i, indirect_pointer_reg1_i);
					state_next.far.is_write = move_i.is_write;
					state_next.far.wdata = move_i.wdata;
					state_next.far.addr = state_next.addr;
					state_next.lat = 2'h0;
					// flash takes writes first, then off-chip, else on-chip ram
					if (route_flash) begin
						state_next.far.to_flash = 1'b1;
						state_next.far.valid = 1'b1;
						state_next.state = ST_OFF;
					end else if (route_off) begin
						state_next.far.to_flash = 1'b0;
						state_next.far.valid = 1'b1;
						state_next.state = ST_OFF;
					end else begin
						state_next.far.to_flash = 1'b0;
						state_next.state = ST_RAM;
					end
				end
			end
			ST_RAM: begin
				// fixed latency: strobe, then capture read data
				if (state_reg.lat == LAT_LAST) begin
					state_next.rdata = state_reg.far.is_write ? state_reg.rdata : ram_rdata;
					state_next.done = 1'b1;
					state_next.state = ST_DONE;
				end else begin
					state_next.lat = state_reg.lat + 2'h1;
				end
			end
			ST_OFF: begin
				// far side may take any time; request stays up until it answers
				// a read keeps the far byte; a write leaves the accumulator copy alone
				if (far_done_i) begin
					state_next.far.valid = 1'b0;
					if (!state_reg.far.is_write) begin
						state_next.rdata = far_rdata_i;
					end
					state_next.done = 1'b1;
					state_next.state = ST_DONE;
				end
			end
			ST_DONE: begin
				// one gap cycle so a held req_i is not taken twice
				// it also gives the far side a clock to drop its done pulse
				state_next.state = ST_IDLE;
			end
			default: state_next.state = ST_IDLE;
		endcase
	end

	// the single state register, frozen while ce_i is low
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			// ram contents are kept; only control state, pointers, page and read byte clear
			state_reg.state <= ST_IDLE;
			state_reg.lat <= 2'h0;
			state_reg.data_pointer <= DATA_POINTER_RESET;
			state_reg.page <= PAGE_RESET;
			state_reg.addr <= DATA_POINTER_RESET;
			state_reg.done <= 1'b0;
			state_reg.rdata <= BYTE_RESET;
			state_reg.far <= '0;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	// outputs straight from flops
	// addr and data stay on far_req_o after valid drops, for a slow port latch
	always_comb begin
		done_o = state_reg.done;
		acc_rdata_o = state_reg.rdata;
		eff_addr_o = state_reg.addr;
		data_pointer_high_half_o = state_reg.data_pointer[15:8];
		data_pointer_low_half_o = state_reg.data_pointer[7:0];
		external_data_space_page_select_reg_o = state_reg.page;
		far_req_o = state_reg.far;
	end
endmodule : external_data_space_access_address_gen

// >>> external_data_space_access_pkg.sv
// Purpose: shared constants and carriers for the external-move address generator
// Assumes: one 250 MHz system clock, byte-wide core data path
// Notes: no software-visible registers live here; the core drives them over ports
package external_data_space_access_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int EXTERNAL_DATA_SPACE_BYTES = 1024;
	localparam int EXTERNAL_DATA_SPACE_AW = 10;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// fixed on-chip access latency in clocks spent in the ram state; request to done takes one clock more
	localparam int EXTERNAL_DATA_SPACE_LATENCY = 2;
	localparam logic [1:0] LAT_LAST = 2'h1;
	// special function register selectors for pointer and page writes
	localparam logic [1:0] SFR_NONE = 2'h0;
	localparam logic [1:0] SFR_DP_HIGH = 2'h1;
	localparam logic [1:0] SFR_DP_LOW = 2'h2;
	localparam logic [1:0] SFR_PAGE = 2'h3;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RAM = 4'b0010,
		ST_OFF = 4'b0100,
		ST_DONE = 4'b1000
	} access_state_e;

	// one external-move request from the core
	typedef struct packed {
		logic wide_form;
		logic use_ptr1;
		logic is_write;
		logic [7:0] wdata;
	} move_req_s;

	// request toward the off-chip port or flash writer
	typedef struct packed {
		logic valid;
		logic is_write;
		logic to_flash;
		logic [15:0] addr;
		logic [7:0] wdata;
	} far_req_s;
endpackage : external_data_space_access_pkg

// >>> external_data_space_access_properties.sv
// Purpose: port checks for external_data_space_access_address_gen
// Assumes: a rising req_i is a fresh access; ce_i stays high
// Notes: far means off-chip selected or a write while flash writing is on
`timescale 1ns/1ps
module external_data_space_access_properties import external_data_space_access_pkg::*; (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic req_i,
	input wire move_req_s move_i,
	input wire logic [7:0] indirect_pointer_reg0_i,
	input wire logic [7:0] indirect_pointer_reg1_i,
	input wire logic [1:0] sfr_sel_i,
	input wire logic sfr_we_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic flash_write_en_i,
	input wire logic offchip_sel_i,
	input wire logic far_done_i,
	input wire logic done_o,
	input wire logic [15:0] eff_addr_o,
	input wire logic [7:0] data_pointer_high_half_o,
	input wire logic [7:0] data_pointer_low_half_o,
	input wire logic [7:0] external_data_space_page_select_reg_o,
	input wire far_req_s far_req_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i || !ce_i);
	logic far;
	// flash writes win over off-chip, which wins over on-chip ram
	assign far = offchip_sel_i || (flash_write_en_i && move_i.is_write);
	done_pulse_a: assert property (done_o |=> !done_o)
		else $error("done wider than one cycle");
	ram_lat_a: assert property ($rose(req_i) && !far |=> !done_o ##1 !done_o ##1 done_o)
		else $error("on-chip access latency wrong");
	wide_addr_a: assert property ($rose(req_i) && move_i.wide_form |=>
		eff_addr_o == {$past(data_pointer_high_half_o), $past(data_pointer_low_half_o)})
		else $error("wide address not the data pointer");
	page_addr_a: assert property ($rose(req_i) && !move_i.wide_form |=>
		eff_addr_o == {$past(external_data_space_page_select_reg_o), $past(move_i.use_ptr1) ?
		$past(indirect_pointer_reg1_i) : $past(indirect_pointer_reg0_i)})
		else $error("paged address wrong");
	far_go_a: assert property ($rose(req_i) && far |=> far_req_o.valid && far_req_o.addr == eff_addr_o)
		else $error("far request missing");
	flash_wr_a: assert property ($rose(req_i) && flash_write_en_i && move_i.is_write |=>
		far_req_o.to_flash && far_req_o.is_write)
		else $error("flash write not routed");
	far_done_a: assert property (far_req_o.valid && far_done_i |=> done_o && !far_req_o.valid)
		else $error("far answer not finished");
	page_wr_a: assert property (sfr_we_i && sfr_sel_i == SFR_PAGE |=>
		external_data_space_page_select_reg_o == $past(sfr_wdata_i))
		else $error("page write lost");
	cover property ($rose(req_i) && !far);
	cover property (far_req_o.valid && far_done_i);
	cover property (sfr_we_i && sfr_sel_i == SFR_PAGE);
endmodule : external_data_space_access_properties

// >>> external_data_space_store.sv
// Purpose: on-chip byte store behind the external data space
// Assumes: one access per cycle, synchronous read
// Notes: read data appears one enabled clock after the request
`timescale 1ns/1ps
module external_data_space_store import external_data_space_access_pkg::*; #(
	parameter int DEPTH = EXTERNAL_DATA_SPACE_BYTES,
	parameter int AW = EXTERNAL_DATA_SPACE_AW
) (
	input wire logic mclk_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	initial begin
		if (DEPTH != (1 << AW)) $error("external_data_space_store: DEPTH must equal 2**AW");
	end

	logic [7:0] mem [DEPTH];

	// no reset on the array: contents are undefined at power-up like a real ram
	always_ff @(posedge mclk_i) begin
		if (ce_i && en_i) begin
			if (we_i) begin
				mem[addr_i] <= wdata_i;
			end
			rdata_o <= mem[addr_i];
		end
	end
endmodule : external_data_space_store

// >>> far_side_model.sv
// Purpose: stand-in for the off-chip port and flash writer
// Assumes: valid holds until done is seen
// Notes: delay set by lat_i; data inverts while idle so a late sample fails
`timescale 1ns/1ps
module far_side_model import external_data_space_access_pkg::*; (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [3:0] lat_i,
	input wire far_req_s far_req_i,
	output logic far_done_o,
	output logic [7:0] far_rdata_o
);
	logic [3:0] cnt_reg;
	logic nxt;
	// one answer per request, after lat_i waiting clocks
	assign nxt = far_req_i.valid && !far_done_o && cnt_reg == lat_i;
	// read byte is a fold of the address so the bench can predict it
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_reg <= 4'h0;
			far_done_o <= 1'b0;
			far_rdata_o <= 8'h00;
		end else begin
			far_done_o <= nxt;
			cnt_reg <= (far_req_i.valid && !far_done_o) ? cnt_reg + 4'h1 : 4'h0;
			far_rdata_o <= nxt ? far_req_i.addr[15:8] ^ far_req_i.addr[7:0] : ~far_rdata_o;
		end
	end
endmodule : far_side_model

// >>> tb.sv
// Purpose: self-checking bench for external_data_space_access_address_gen
// Assumes: ce_i stays high; inputs change 1 ns after the rising edge
// Notes: cycle counts come from the access walk, read bytes from the model
`timescale 1ns/1ps
module tb import external_data_space_access_pkg::*; ();
	logic mclk_i = 0, reset_i = 1, ce_i = 1, req_i = 0, sfr_we_i = 0;
	logic data_pointer_load_i = 0;
	logic flash_write_en_i = 0, offchip_sel_i = 0, far_done_i, done_o;
	logic [1:0] sfr_sel_i = '0;
	logic [3:0] lat = '0;
	logic [7:0] indirect_pointer_reg0_i = '0, indirect_pointer_reg1_i = '0, sfr_wdata_i = '0;
	logic [7:0] far_rdata_i, acc_rdata_o, data_pointer_high_half_o, data_pointer_low_half_o;
	logic [7:0] external_data_space_page_select_reg_o;
	logic [15:0] data_pointer_wdata_i = '0, eff_addr_o;
	move_req_s move_i = '0;
	far_req_s far_req_o;
	int n_mismatch = 0, tests_run = 0;
	external_data_space_access_address_gen DUT (.*);
	far_side_model peer (.mclk_i, .reset_i, .lat_i(lat), .far_req_i(far_req_o),
		.far_done_o(far_done_i), .far_rdata_o(far_rdata_i));
	initial forever #2 mclk_i = ~mclk_i;
	task automatic tick();
		@(posedge mclk_i);
		#1;
	endtask : tick
	task automatic chk(logic [23:0] got, logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic sfr(logic [1:0] s, logic [7:0] d);
		sfr_sel_i = s;
		sfr_wdata_i = d;
		sfr_we_i = 1;
		tick();
		// strobes drop, then a clock passes so the next call never re-raises them at once
		sfr_we_i = 0;
		data_pointer_load_i = 0;
		tick();
	endtask : sfr
	// request held until done, then two idle clocks before the next one
	task automatic mv(logic w, p1, wr, logic [7:0] d, logic [23:0] c);
		logic [23:0] n;
		move_i = '{w, p1, wr, d};
		req_i = 1;
		n = 0;
		while (done_o !== 1'b1 && n < 40) begin
			tick();
			n++;
		end
		req_i = 0;
		chk(n, c);
		repeat (2) tick();
	endtask : mv
	task automatic t_ptr();
		chk({data_pointer_high_half_o, data_pointer_low_half_o, external_data_space_page_select_reg_o}, '0);
		sfr(SFR_DP_HIGH, 8'h12);
		sfr(SFR_DP_LOW, 8'h34);
		sfr(SFR_PAGE, 8'h07);
		chk({data_pointer_high_half_o, data_pointer_low_half_o, external_data_space_page_select_reg_o}, 24'h12_3407);
		data_pointer_wdata_i = 16'hABCD;
		data_pointer_load_i = 1;
		sfr(SFR_DP_LOW, 8'h05); // byte write in the load cycle wins its half
		chk({data_pointer_high_half_o, data_pointer_low_half_o}, 16'hAB05);
		$display("pointer test done");
	endtask : t_ptr
	// 0xAB05 and 0x0705 share the low ten bits, so they alias in the 1k ram
	task automatic t_ram();
		mv(1, 0, 1, 8'hA5, EXTERNAL_DATA_SPACE_LATENCY + 1);
		chk(eff_addr_o, 16'hAB05);
		indirect_pointer_reg0_i = 8'hFF;
		indirect_pointer_reg1_i = 8'h05;
		mv(0, 1, 0, 8'h00, EXTERNAL_DATA_SPACE_LATENCY + 1);
		chk(eff_addr_o, 16'h0705);
		chk(acc_rdata_o, 8'hA5);
		flash_write_en_i = 1;
		mv(0, 0, 0, 8'h00, EXTERNAL_DATA_SPACE_LATENCY + 1);
		chk(eff_addr_o, 16'h07FF);
		chk({far_req_o.valid, far_req_o.to_flash}, 2'h0);
		flash_write_en_i = 0;
		$display("ram test done");
	endtask : t_ram
	task automatic t_far();
		offchip_sel_i = 1;
		lat = 2;
		mv(0, 0, 0, 8'h00, 5);
		chk(far_req_o.addr, 16'h07FF);
		chk(acc_rdata_o, 8'hF8);
		offchip_sel_i = 0;
		lat = 0;
		flash_write_en_i = 1;
		mv(1, 0, 1, 8'h3C, 3);
		chk(acc_rdata_o, 8'hF8);
		chk({far_req_o.valid, far_req_o.to_flash, far_req_o.is_write, far_req_o.wdata}, 11'h33C);
		chk(far_req_o.addr, 16'hAB05);
		flash_write_en_i = 0;
		$display("far test done");
	endtask : t_far
	// a reset in mid-run clears pointers, page, read byte and done
	task automatic t_rst();
		reset_i = 1;
		tick();
		chk({data_pointer_high_half_o, data_pointer_low_half_o, external_data_space_page_select_reg_o}, '0);
		chk({done_o, acc_rdata_o, far_req_o.valid}, '0);
		chk(eff_addr_o, '0);
		reset_i = 0;
		tick();
		$display("reset test done");
	endtask : t_rst
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	initial begin
		repeat (8) @(posedge mclk_i);
		#1 reset_i = 0;
		t_ptr();
		t_ram();
		t_far();
		t_rst();
		test_done();
	end
	// about 45 clocks of work; 1000 clocks means a hang
	initial begin
		#4000;
		n_mismatch++;
		test_done();
	end
endmodule : tb
bind external_data_space_access_address_gen external_data_space_access_properties chk (.*);
